/* logic/slc_pkg.sv */
// Shared constants, types and helpers for the link capability register bank
`default_nettype none
package slc_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADR_CTRL_STAT = 8'hE8;
    localparam logic [7:0] ADR_LINK_CAP  = 8'hEC;
    localparam logic [7:0] ADR_IRQ_MASK  = 8'hF8;
    // ==========================================================
    // Field positions
    localparam int N_ERR       = 4;
    localparam int CTL_MPS_LSB = 5;
    localparam int CTL_AUX_PM  = 10;
    localparam int STS_ERR_LSB = 16;
    localparam int STS_AUX_DET = 20;
    localparam int CAP_WID_LSB = 4;
    localparam int CAP_PM_LSB  = 10;
    localparam int CAP_L0S_LSB = 12;
    localparam int CAP_L1_LSB  = 15;
    // ==========================================================
    // Values after reset
    localparam logic [3:0] CAP_SPEED_RST = 4'h1;
    localparam logic [5:0] CAP_WIDTH_RST = 6'h01;
    localparam logic [1:0] CAP_PM_RST    = 2'h3;
    localparam logic [2:0] CAP_L0S_RST   = 3'h3;
    localparam logic [2:0] CAP_L1_RST    = 3'h0;
    localparam logic [2:0] CTL_MPS_RST   = 3'h0;
    localparam logic       AUX_DET_RST   = 1'b1;
    // ==========================================================
    // Bus slave states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK  = 2'b10
    } slc_bus_e;

    // Word address match, used for every register decode
    function automatic logic slc_hit(input logic [7:0] adr,
                                     input logic [7:0] reg_adr);
        slc_hit = (adr[7:2] == reg_adr[7:2]);
    endfunction
endpackage
`default_nettype wire

/* logic/slc_flag_if.sv */
// Interface between the register front end and the error flag bank
`timescale 1ns/1ps
`default_nettype none
interface slc_flag_if;
    logic [3:0] event_set;
    logic [3:0] clear;
    logic [3:0] mask;
    logic [3:0] flags;
    logic       irq;
    modport bank  (input event_set, clear, mask, output flags, irq);
    modport front (output event_set, clear, mask, input flags, irq);
endinterface
`default_nettype wire

/* logic/slc_flag_bank.sv */
// Sticky write-one-to-clear error flags with masked interrupt
`timescale 1ns/1ps
`default_nettype none
module slc_flag_bank
    import slc_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    slc_flag_if.bank    fl
);
    logic [N_ERR-1:0] flags;
    logic [N_ERR-1:0] next_flags;

    // ==========================================================
    // Flag update
    // Set on detect
    always_comb begin
        next_flags = (flags & ~fl.clear) | fl.event_set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // Level interrupt, follows the stored flags gated by the mask
    assign fl.flags = flags;
    assign fl.irq   = |(flags & fl.mask);
endmodule // slc_flag_bank
`default_nettype wire

/* logic/slc_cap_regs.sv */
// Device control/status and link capability registers on classic Wishbone
//
// Notes on behaviour
// - Four error reporting enables in control bits 3:0, reset zero.
// - Unimplemented control and status fields read zero, writes ignored.
// - Payload limit field in control bits 7:5, read-write, resets 000b.
// - A payload limit above the supported capability stores the capability.
// - Status bits 19:16 set on detected errors, cleared by writing one.
// - Errors are recorded whatever the reporting enables say.
// - Status bit 20 shows standby auxiliary power present, resets one.
// - Link capabilities bits 3:0 read 0001b, 2.5 Gb/s.
// - Link capabilities bits 9:4 report single-lane maximum width.
// - Bits 11:10 report power-saving support, reset 11b.
// - Bits 14:12 report L0s exit latency, reset 011b.
// - Bits 17:15 report L1 exit latency, reset 000b.
// - Support and latency fields may be replaced by EEPROM-loaded values.
// - Control in bits 15:0 and status in 31:16 of word E8h.
// - Link capabilities register sits at offset ECh.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module slc_cap_regs
    import slc_pkg::*;
#(
    // Largest payload setting the datapath supports
    parameter logic [2:0] MPS_CAP = 3'h1
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        soft_rst_i,
    // Wishbone classic slave
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    // Error detection strobes, core clock
    input  wire logic        err_corr_i,
    input  wire logic        err_nonfatal_i,
    input  wire logic        err_fatal_i,
    input  wire logic        err_unsup_i,
    // Standby power sense pin, asynchronous
    input  wire logic        aux_pwr_pin_i,
    // EEPROM loaded capability values
    input  wire logic        ee_load_i,
    input  wire logic [1:0]  ee_pm_support_i,
    input  wire logic [2:0]  ee_l0s_lat_i,
    input  wire logic [2:0]  ee_l1_lat_i,
    // Block outputs
    output logic      [2:0]  max_payload_o,
    output logic             aux_pm_en_o,
    output logic      [3:0]  err_report_o,
    output logic             irq_o
);
    // ==========================================================
    // Declarations
    slc_flag_if fl ();

    slc_bus_e         state;
    slc_bus_e         next_state;
    logic [31:0]      rd_data;
    logic [31:0]      next_rd_data;
    logic [31:0]      rd_mux;

    logic             fn_rst;
    logic             wr_fire;
    logic             wr_ctl;
    logic             wr_mask;

    logic [N_ERR-1:0] rep_en;
    logic [N_ERR-1:0] next_rep_en;
    logic [2:0]       mps;
    logic [2:0]       next_mps;
    logic [2:0]       mps_wr;
    logic             aux_pm;
    logic             next_aux_pm;
    logic [N_ERR-1:0] mask;
    logic [N_ERR-1:0] next_mask;

    logic [N_ERR-1:0] err_vec;
    logic [N_ERR-1:0] report;
    logic [N_ERR-1:0] next_report;

    logic             aux_meta;
    logic             aux_sync;
    logic             aux_det;
    logic             next_aux_det;

    logic [1:0]       pm_sup;
    logic [1:0]       next_pm_sup;
    logic [2:0]       l0s_lat;
    logic [2:0]       next_l0s_lat;
    logic [2:0]       l1_lat;
    logic [2:0]       next_l1_lat;

    // Functional reset clears enables, payload limit, mask, flags and report only
    assign fn_rst = rst_i | soft_rst_i;

    // ==========================================================
    // Bus slave sequencing
    // One wait state: request seen, then ack for one cycle.
    // Writes land on the acknowledged edge so master and slave agree.
    // Two edges per access; ample for configuration traffic.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (cyc_i && stb_i) begin
                    next_state = ST_ACK;
                end
            end
            ST_ACK: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign ack_o   = (state == ST_ACK);
    assign wr_fire = ack_o && cyc_i && stb_i && we_i;

    // Address decode for writable words
    // Control and status share E8h
    assign wr_ctl  = wr_fire && slc_hit(adr_i, ADR_CTRL_STAT);
    assign wr_mask = wr_fire && slc_hit(adr_i, ADR_IRQ_MASK);

    // ==========================================================
    // Read path
    // Unimplemented fields hardwired zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (slc_hit(adr_i, ADR_CTRL_STAT)) begin
            rd_mux[N_ERR-1:0]                    = rep_en;
            rd_mux[CTL_MPS_LSB +: 3]             = mps;
            rd_mux[CTL_AUX_PM]                   = aux_pm;
            rd_mux[STS_ERR_LSB +: N_ERR]         = fl.flags;
            rd_mux[STS_AUX_DET]                  = aux_det;
        end else if (slc_hit(adr_i, ADR_LINK_CAP)) begin
            rd_mux[3:0]                          = CAP_SPEED_RST;
            rd_mux[CAP_WID_LSB +: 6]             = CAP_WIDTH_RST;
            rd_mux[CAP_PM_LSB +: 2]              = pm_sup;
            rd_mux[CAP_L0S_LSB +: 3]             = l0s_lat;
            rd_mux[CAP_L1_LSB +: 3]              = l1_lat;
        end else if (slc_hit(adr_i, ADR_IRQ_MASK)) begin
            rd_mux[STS_ERR_LSB +: N_ERR]         = mask;
        end
    end

    // Read data captured as the request is taken; unmapped gives zero
    // Capturing early keeps dat_o steady for the whole ack cycle.
    always_comb begin
        next_rd_data = rd_data;
        if (state == ST_IDLE && cyc_i && stb_i) begin
            next_rd_data = we_i ? 32'h0000_0000 : rd_mux;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data <= 32'h0000_0000;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // Read data straight from its register
    assign dat_o = rd_data;

    // ==========================================================
    // Device control
    // Payload limit clamp; the comparison is unsigned on the code.
    // Clamp to capability
    assign mps_wr = (dat_i[CTL_MPS_LSB +: 3] > MPS_CAP) ?
                    MPS_CAP : dat_i[CTL_MPS_LSB +: 3];

    always_comb begin
        next_rep_en = rep_en;
        next_mps    = mps;
        next_mask   = mask;
        if (wr_ctl && sel_i[0]) begin
            next_rep_en = dat_i[N_ERR-1:0];
            next_mps    = mps_wr;
        end
        if (wr_mask && sel_i[2]) begin
            next_mask = dat_i[STS_ERR_LSB +: N_ERR];
        end
    end

    // Mask shares the functional reset, so a soft reset quiets the interrupt
    // Enables reset to zero
    always_ff @(posedge clk_i) begin
        if (fn_rst) begin
            rep_en <= '0;
            mps    <= CTL_MPS_RST;
            mask   <= '0;
        end else begin
            rep_en <= next_rep_en;
            mps    <= next_mps;
            mask   <= next_mask;
        end
    end

    // Sticky enable survives the functional reset
    always_comb begin
        next_aux_pm = aux_pm;
        if (wr_ctl && sel_i[1]) begin
            next_aux_pm = dat_i[CTL_AUX_PM];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_pm <= 1'b0;
        end else begin
            aux_pm <= next_aux_pm;
        end
    end

    // Registered field values straight to the pins
    assign max_payload_o = mps;
    assign aux_pm_en_o   = aux_pm;

    // ==========================================================
    // Device status flags
    // Detect strobes gathered in status bit order
    assign err_vec = {err_unsup_i, err_fatal_i, err_nonfatal_i, err_corr_i};

    assign fl.event_set = err_vec;
    // Only byte lane two clears, so control writes never touch the flags
    // Only ones clear
    assign fl.clear = (wr_ctl && sel_i[2]) ?
                      dat_i[STS_ERR_LSB +: N_ERR] : '0;
    assign fl.mask  = mask;

    // Flags on the functional reset: status bits 19:16 do not survive a soft reset
    slc_flag_bank u_flags (
        .clk_i (clk_i),
        .rst_i (fn_rst),
        .fl    (fl.bank)
    );

    // Level output; drops only when the flag or its mask bit is cleared
    assign irq_o = fl.irq;

    // Reporting pulse per enabled error class, one cycle after detect
    // Registered so the pulse is clean, at the cost of one cycle of lag
    always_comb begin
        next_report = err_vec & rep_en;
    end

    always_ff @(posedge clk_i) begin
        if (fn_rst) begin
            report <= '0;
        end else begin
            report <= next_report;
        end
    end

    assign err_report_o = report;

    // ==========================================================
    // Standby power sense
    // Two stages before use; the pin is not on this clock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_meta <= AUX_DET_RST;
            aux_sync <= AUX_DET_RST;
        end else begin
            aux_meta <= aux_pwr_pin_i;
            aux_sync <= aux_meta;
        end
    end

    always_comb begin
        next_aux_det = aux_sync;
    end

    // Reset value one: software sees no false power loss after reset
    // Resets to one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_det <= AUX_DET_RST;
        end else begin
            aux_det <= next_aux_det;
        end
    end

    // ==========================================================
    // Link capabilities, EEPROM overridable
    // Loaded values persist until the next rst_i restores defaults; a soft reset keeps them.
    // A read racing a load pulse may return either value; read after loading.
    always_comb begin
        next_pm_sup  = pm_sup;
        next_l0s_lat = l0s_lat;
        next_l1_lat  = l1_lat;
        if (ee_load_i) begin
            next_pm_sup  = ee_pm_support_i;
            next_l0s_lat = ee_l0s_lat_i;
            next_l1_lat  = ee_l1_lat_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pm_sup  <= CAP_PM_RST;
            l0s_lat <= CAP_L0S_RST;
            l1_lat  <= CAP_L1_RST;
        end else begin
            pm_sup  <= next_pm_sup;
            l0s_lat <= next_l0s_lat;
            l1_lat  <= next_l1_lat;
        end
    end
endmodule // slc_cap_regs
`default_nettype wire

/* verification/slc_cap_regs_checker.sv */
// Port-level checker for the capability register bank
`timescale 1ns/1ps
`default_nettype none
module slc_cap_regs_checker
    import slc_pkg::*;
#(
    parameter logic [2:0] MPS_CAP = 3'h1
)(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        soft_rst_i,
    input wire logic [7:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic [3:0]  sel_i,
    input wire logic        we_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic        err_corr_i,
    input wire logic        err_nonfatal_i,
    input wire logic        err_fatal_i,
    input wire logic        err_unsup_i,
    input wire logic        aux_pwr_pin_i,
    input wire logic        ee_load_i,
    input wire logic [1:0]  ee_pm_support_i,
    input wire logic [2:0]  ee_l0s_lat_i,
    input wire logic [2:0]  ee_l1_lat_i,
    input wire logic [2:0]  max_payload_o,
    input wire logic        aux_pm_en_o,
    input wire logic [3:0]  err_report_o,
    input wire logic        irq_o
);
    // ==========================================================
    // Bus steps
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request taken by an idle slave; cycles with soft reset are left out
    sequence s_take;
        cyc_i && stb_i && !ack_o && !soft_rst_i;
    endsequence
    // Read taken at one word
    sequence s_rd(logic [7:0] a);
        s_take ##0 (!we_i && adr_i[7:2] == a[7:2]);
    endsequence
    // ==========================================================
    // Checks
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held past one cycle");
    ack_latency_a: assert property (s_take |=> ack_o)
        else $error("no ack one cycle after request");
    ctl_zero_a: assert property (s_rd(ADR_CTRL_STAT) |=> (dat_o & 32'hFFE0_FB10) == 32'h0)
        else $error("unimplemented control bits not zero");
    cap_fixed_a: assert property (s_rd(ADR_LINK_CAP) |=> dat_o[9:0] == 10'h011
        && dat_o[31:18] == 14'h0) else $error("fixed capability fields wrong");
    unmapped_zero_a: assert property (s_take ##0 (!we_i && adr_i[7:2] != ADR_CTRL_STAT[7:2]
        && adr_i[7:2] != ADR_LINK_CAP[7:2] && adr_i[7:2] != ADR_IRQ_MASK[7:2]) |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    payload_clamp_a: assert property (max_payload_o <= MPS_CAP)
        else $error("payload limit above capability");
    report_cause_a: assert property ((err_report_o & ~$past({err_unsup_i, err_fatal_i,
        err_nonfatal_i, err_corr_i})) == 4'h0) else $error("report without detect");
    aux_sticky_a: assert property (!(ack_o && we_i && sel_i[1]
        && adr_i[7:2] == ADR_CTRL_STAT[7:2]) |=> $stable(aux_pm_en_o))
        else $error("aux enable changed without write");
    reset_vals_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o
        && err_report_o == 4'h0 && max_payload_o == 3'h0 && !aux_pm_en_o)
        else $error("outputs not at reset values");
endmodule // slc_cap_regs_checker
bind slc_cap_regs slc_cap_regs_checker #(.MPS_CAP(MPS_CAP)) u_chk (
    .clk_i (clk_i), .rst_i (rst_i), .soft_rst_i (soft_rst_i),
    .adr_i (adr_i), .dat_i (dat_i), .dat_o (dat_o), .sel_i (sel_i),
    .we_i (we_i), .cyc_i (cyc_i), .stb_i (stb_i), .ack_o (ack_o),
    .err_corr_i (err_corr_i), .err_nonfatal_i (err_nonfatal_i),
    .err_fatal_i (err_fatal_i), .err_unsup_i (err_unsup_i),
    .aux_pwr_pin_i (aux_pwr_pin_i), .ee_load_i (ee_load_i),
    .ee_pm_support_i (ee_pm_support_i), .ee_l0s_lat_i (ee_l0s_lat_i),
    .ee_l1_lat_i (ee_l1_lat_i), .max_payload_o (max_payload_o),
    .aux_pm_en_o (aux_pm_en_o), .err_report_o (err_report_o), .irq_o (irq_o)
);
`default_nettype wire

/* verification/slc_cap_regs_tb.sv */
// Self-checking bench for the capability register bank
`timescale 1ns/1ps
`default_nettype none
module slc_cap_regs_tb;
    import slc_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic        clk_i = '0, rst_i = '1, soft_rst_i = '0, we_i = '0, cyc_i = '0, stb_i = '0;
    logic [7:0]  adr_i = '0;
    logic [31:0] dat_i = '0, dat_o, rd;
    logic [3:0]  sel_i = '0, err_report_o;
    logic        err_corr_i = '0, err_nonfatal_i = '0, err_fatal_i = '0, err_unsup_i = '0;
    logic        aux_pwr_pin_i = '1, ee_load_i = '0, ack_o, irq_o, aux_pm_en_o;
    logic [1:0]  ee_pm_support_i = '0;
    logic [2:0]  ee_l0s_lat_i = '0, ee_l1_lat_i = '0, max_payload_o;
    int          mismatches = 0, n_compared = 0;
    // Clamp target two, so writes both below and above it are meaningful
    slc_cap_regs #(.MPS_CAP(3'h2)) dut (
        .clk_i (clk_i), .rst_i (rst_i), .soft_rst_i (soft_rst_i),
        .adr_i (adr_i), .dat_i (dat_i), .dat_o (dat_o), .sel_i (sel_i),
        .we_i (we_i), .cyc_i (cyc_i), .stb_i (stb_i), .ack_o (ack_o),
        .err_corr_i (err_corr_i), .err_nonfatal_i (err_nonfatal_i),
        .err_fatal_i (err_fatal_i), .err_unsup_i (err_unsup_i),
        .aux_pwr_pin_i (aux_pwr_pin_i), .ee_load_i (ee_load_i),
        .ee_pm_support_i (ee_pm_support_i), .ee_l0s_lat_i (ee_l0s_lat_i),
        .ee_l1_lat_i (ee_l1_lat_i), .max_payload_o (max_payload_o),
        .aux_pm_en_o (aux_pm_en_o), .err_report_o (err_report_o), .irq_o (irq_o)
    );
    // 200 MHz clock
    initial forever #2.5 clk_i = ~clk_i;
    // ==========================================================
    // Shared tasks
    task automatic ev(input logic [3:0] e);
        {err_unsup_i, err_fatal_i, err_nonfatal_i, err_corr_i} <= e;
    endtask
    // One classic cycle; e is raised in the ack cycle to meet the write edge
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s, input logic [3:0] e = 4'h0);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        @(posedge clk_i);
        ev(e);
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        ev(4'h0);
        @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        wb(a, 1'b0, 32'h0, 4'hF);
        chk(rd, x);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_ctrl;
        rdc(ADR_CTRL_STAT, 32'h0010_0000);
        rdc(ADR_LINK_CAP, 32'h0000_3C11);
        rdc(8'hF0, 32'h0);
        rdc(ADR_IRQ_MASK, 32'h0);
        wb(ADR_CTRL_STAT, 1'b1, 32'hFFFF_FFFF, 4'hF);
        rdc(ADR_CTRL_STAT, 32'h0010_044F);
        wb(ADR_CTRL_STAT, 1'b1, 32'h0000_0040, 4'h1);
        rdc(ADR_CTRL_STAT, 32'h0010_0440);
        chk(32'(max_payload_o), 32'h2);
        wb(ADR_LINK_CAP, 1'b1, 32'hFFFF_FFFF, 4'hF);
        rdc(ADR_LINK_CAP, 32'h0000_3C11);
        $display("test ctrl done");
    endtask
    task automatic t_err;
        for (int i = 0; i < 4; i++) begin
            wb(ADR_CTRL_STAT, 1'b1, 32'h1 << i, 4'h1);
            ev(4'hF);
            @(posedge clk_i);
            ev(4'h0);
            @(posedge clk_i);
            chk(32'(err_report_o), 32'h1 << i);
            rdc(ADR_CTRL_STAT, 32'h001F_0400 | (32'h1 << i));
            wb(ADR_CTRL_STAT, 1'b1, 32'h0, 4'h4);
            rdc(ADR_CTRL_STAT, 32'h001F_0400 | (32'h1 << i));
            wb(ADR_CTRL_STAT, 1'b1, 32'h000F_0000, 4'h4);
            rdc(ADR_CTRL_STAT, 32'h0010_0400 | (32'h1 << i));
        end
        // Clear and new error meet on one edge
        wb(ADR_CTRL_STAT, 1'b1, 32'h0001_0000, 4'h4, 4'h1);
        rdc(ADR_CTRL_STAT, 32'h0011_0408);
        $display("test err done");
    endtask
    task automatic t_irq;
        wb(ADR_IRQ_MASK, 1'b1, 32'h0001_0000, 4'h4);
        chk(32'(irq_o), 32'h1);
        wb(ADR_IRQ_MASK, 1'b1, 32'h0, 4'h4);
        chk(32'(irq_o), 32'h0);
        wb(ADR_IRQ_MASK, 1'b1, 32'h0001_0000, 4'h4);
        rdc(ADR_IRQ_MASK, 32'h0001_0000);
        wb(ADR_CTRL_STAT, 1'b1, 32'h0001_0000, 4'h4);
        chk(32'(irq_o), 32'h0);
        $display("test irq done");
    endtask
    task automatic t_misc;
        ee_pm_support_i <= 2'h1;
        ee_l0s_lat_i <= 3'h5;
        ee_l1_lat_i <= 3'h6;
        ee_load_i <= 1'b1;
        @(posedge clk_i);
        ee_load_i <= 1'b0;
        rdc(ADR_LINK_CAP, 32'h0003_5411);
        aux_pwr_pin_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rdc(ADR_CTRL_STAT, 32'h0000_0408);
        soft_rst_i <= 1'b1;
        @(posedge clk_i);
        soft_rst_i <= 1'b0;
        rdc(ADR_CTRL_STAT, 32'h0000_0400);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(32'(aux_pm_en_o), 32'h0);
        $display("test misc done");
    endtask
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_ctrl;
        t_err;
        t_irq;
        t_misc;
        test_done;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        test_done;
    end
endmodule // slc_cap_regs_tb
`default_nettype wire
